// [design/dpsd_pkg.sv]
// Shared constants for the dual potentiometer serial command decoder
//
// Behaviour
// - Global load copies chosen slot into both wipers
// - Global store saves both wipers into chosen slot
// - Single store saves one wiper into chosen slot
// - Single load copies chosen slot into one wiper
// - Stepping command then direction bits until deselect
// - Non-volatile write starts only after deselect
// - Status byte bit zero shows write busy
// - Step bit high moves up, low moves down
// - Busy flag held for full write time
package dpsd_pkg;
    // ---------------------------------------------------------------
    // Frame layout
    // ---------------------------------------------------------------
    localparam int unsigned  BYTE_BITS     = 8;
    localparam int unsigned  HDR_BITS      = 16;
    localparam logic [4:0]   ADDR_DONE_CNT = 5'h07;
    localparam logic [4:0]   INSTR_DONE_CNT = 5'h0f;
    localparam logic [4:0]   DATA_CNT      = 5'h10;
    localparam logic [5:0]   DEV_ADDR_PAT  = 6'h14;
    // ---------------------------------------------------------------
    // Instruction encodings
    // ---------------------------------------------------------------
    localparam logic [3:0]   OP_GLOBAL_LOAD  = 4'h1;
    localparam logic [3:0]   OP_GLOBAL_STORE = 4'h8;
    localparam logic [3:0]   OP_SINGLE_LOAD  = 4'hd;
    localparam logic [3:0]   OP_SINGLE_STORE = 4'he;
    localparam logic [6:0]   OP_STEP_HI7     = 7'h10;
    localparam logic [7:0]   OP_READ_STATUS  = 8'h51;
    localparam int unsigned  WIP_BIT         = 0;
    // ---------------------------------------------------------------
    // Potentiometer geometry
    // ---------------------------------------------------------------
    localparam int unsigned  POTS       = 2;
    localparam int unsigned  SLOTS      = 4;
    localparam int unsigned  WIPER_W    = 6;
    localparam logic [5:0]   WIPER_MAX  = 6'h3f;
    localparam logic [5:0]   WIPER_RST  = 6'h00;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int unsigned  CLK_NS       = 100;
    localparam int unsigned  T_WR_NS      = 5000000;
    localparam int unsigned  WR_CYCLES    = (T_WR_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned  SCK_HALF_DEF = 8;
endpackage

// [design/dpsd_if.sv]
// Serial link between the potentiometer decoder and its host
`timescale 1ns/100ps
interface dpsd_if;
    logic cs_b;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic so_line;

    // Undriven serial output floats high on the board
    assign so_line = so_oe ? so : 1'b1;

    modport dev (
        input  cs_b,
        input  sck,
        input  si,
        output so,
        output so_oe
    );
    modport host (
        output cs_b,
        output sck,
        output si,
        input  so_line
    );
endinterface

// [design/dpsd_device.sv]
// Device end: serial frame decoder, wiper registers and saved slots
`timescale 1ns/100ps
module dpsd_device
    import dpsd_pkg::*;
#(
    parameter int unsigned WR_TIME = WR_CYCLES
) (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    // Serial link
    dpsd_if.dev                      link,
    // Straps
    input  wire logic                strap_addr_high_i,
    input  wire logic                strap_addr_low_i,
    // Wiper outputs and status
    output logic [WIPER_W-1:0]       wiper0_o,
    output logic [WIPER_W-1:0]       wiper1_o,
    output logic                     write_in_progress_flag_o
);
    localparam int unsigned CW = $clog2(WR_TIME + 1);

    typedef enum logic [3:0] {
        M_IDLE = 4'b0001,
        M_STEP = 4'b0010,
        M_STAT = 4'b0100,
        M_SKIP = 4'b1000
    } dpsd_mode_t;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] cs_sync_reg;
    logic [1:0] sck_sync_reg;
    logic [1:0] si_sync_reg;
    logic [1:0] a_hi_sync_reg;
    logic [1:0] a_lo_sync_reg;
    logic       cs_last_reg;
    logic       sck_last_reg;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cs_sync_reg   <= 2'h3;
            sck_sync_reg  <= 2'h0;
            si_sync_reg   <= 2'h0;
            a_hi_sync_reg <= 2'h0;
            a_lo_sync_reg <= 2'h0;
            cs_last_reg   <= 1'b1;
            sck_last_reg  <= 1'b0;
        end else begin
            cs_sync_reg   <= {cs_sync_reg[0], link.cs_b};
            sck_sync_reg  <= {sck_sync_reg[0], link.sck};
            si_sync_reg   <= {si_sync_reg[0], link.si};
            a_hi_sync_reg <= {a_hi_sync_reg[0], strap_addr_high_i};
            a_lo_sync_reg <= {a_lo_sync_reg[0], strap_addr_low_i};
            cs_last_reg   <= cs_sync_reg[1];
            sck_last_reg  <= sck_sync_reg[1];
        end
    end

    logic cs_b_s;
    logic si_s;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    assign cs_b_s   = cs_sync_reg[1];
    assign si_s     = si_sync_reg[1];
    assign sck_rise = sck_sync_reg[1] & ~sck_last_reg & ~cs_b_s;
    assign sck_fall = ~sck_sync_reg[1] & sck_last_reg & ~cs_b_s;
    assign cs_rise  = cs_b_s & ~cs_last_reg;

    // ---------------------------------------------------------------
    // Decoder state
    // ---------------------------------------------------------------
    logic [WIPER_W-1:0] wiper_position_reg [POTS];
    logic [WIPER_W-1:0] wiper_position_next [POTS];
    logic [WIPER_W-1:0] saved_setting_slot [POTS][SLOTS];
    logic [WIPER_W-1:0] saved_setting_next [POTS][SLOTS];
    dpsd_mode_t         mode_reg;
    dpsd_mode_t         mode_next;
    logic [4:0]         bit_cnt_reg;
    logic [4:0]         bit_cnt_next;
    logic [7:0]         in_sh_reg;
    logic [7:0]         in_sh_next;
    logic [7:0]         out_sh_reg;
    logic [7:0]         out_sh_next;
    logic               so_reg;
    logic               so_next;
    logic               so_oe_reg;
    logic               so_oe_next;
    logic               pot_reg;
    logic               pot_next;
    logic [1:0]         slot_reg;
    logic [1:0]         slot_next;
    logic               st_pend_reg;
    logic               st_pend_next;
    logic               st_all_reg;
    logic               st_all_next;
    logic [CW-1:0]      wr_cnt_reg;
    logic [CW-1:0]      wr_cnt_next;
    logic               wip_reg;
    logic               wip_next;

    logic [7:0] byte_in;
    assign byte_in = {in_sh_reg[6:0], si_s};

    always_comb begin
        wiper_position_next = wiper_position_reg;
        saved_setting_next  = saved_setting_slot;
        mode_next    = mode_reg;
        bit_cnt_next = bit_cnt_reg;
        in_sh_next   = in_sh_reg;
        out_sh_next  = out_sh_reg;
        so_next      = so_reg;
        so_oe_next   = so_oe_reg;
        pot_next     = pot_reg;
        slot_next    = slot_reg;
        st_pend_next = st_pend_reg;
        st_all_next  = st_all_reg;
        wr_cnt_next  = wr_cnt_reg;
        wip_next     = wip_reg;

        // Write timer; busy drops only after the full count
        if (wip_reg) begin
            if (wr_cnt_reg == CW'(1)) begin
                wip_next = 1'b0;
            end
            wr_cnt_next = wr_cnt_reg - CW'(1);
        end

        if (sck_rise && bit_cnt_reg < DATA_CNT) begin
            in_sh_next   = byte_in;
            bit_cnt_next = bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == ADDR_DONE_CNT &&
                byte_in != {DEV_ADDR_PAT, a_hi_sync_reg[1], a_lo_sync_reg[1]}) begin
                mode_next = M_SKIP;
            end
            if (bit_cnt_reg == INSTR_DONE_CNT && mode_reg == M_IDLE) begin
                pot_next  = byte_in[0];
                slot_next = byte_in[3:2];
                mode_next = M_SKIP;
                if (byte_in[7:4] == OP_GLOBAL_LOAD && byte_in[1:0] == 2'h0) begin
                    for (int p = 0; p < POTS; p++) begin
                        wiper_position_next[p] = saved_setting_slot[p][byte_in[3:2]];
                    end
                end else if (byte_in[7:4] == OP_SINGLE_LOAD && !byte_in[1]) begin
                    wiper_position_next[byte_in[0]] =
                        saved_setting_slot[byte_in[0]][byte_in[3:2]];
                end else if (byte_in[7:4] == OP_GLOBAL_STORE && byte_in[1:0] == 2'h0) begin
                    st_pend_next = 1'b1;
                    st_all_next  = 1'b1;
                end else if (byte_in[7:4] == OP_SINGLE_STORE && !byte_in[1]) begin
                    st_pend_next = 1'b1;
                    st_all_next  = 1'b0;
                end else if (byte_in[7:1] == OP_STEP_HI7) begin
                    mode_next = M_STEP;
                end else if (byte_in == OP_READ_STATUS) begin
                    mode_next   = M_STAT;
                    out_sh_next = 8'h00;
                    out_sh_next[WIP_BIT] = wip_reg;
                end
            end
        end

        // Each direction bit after the stepping command moves one tap, holding at zero and at WIPER_MAX
        if (sck_rise && bit_cnt_reg == DATA_CNT && mode_reg == M_STEP) begin
            if (si_s && wiper_position_reg[pot_reg] != WIPER_MAX) begin
                wiper_position_next[pot_reg] = wiper_position_reg[pot_reg] + 6'h01;
            end else if (!si_s && wiper_position_reg[pot_reg] != 6'h00) begin
                wiper_position_next[pot_reg] = wiper_position_reg[pot_reg] - 6'h01;
            end
        end

        if (sck_fall && mode_reg == M_STAT && bit_cnt_reg == DATA_CNT) begin
            so_next     = out_sh_reg[7];
            out_sh_next = {out_sh_reg[6:0], 1'b0};
            so_oe_next  = 1'b1;
        end

        if (cs_b_s) begin
            mode_next    = M_IDLE;
            bit_cnt_next = 5'h00;
            so_oe_next   = 1'b0;
            so_next      = 1'b0;
        end

        // Programming waits for deselect; a busy array ignores new stores
        if (cs_rise && st_pend_reg) begin
            st_pend_next = 1'b0;
            if (!wip_reg) begin
                for (int p = 0; p < POTS; p++) begin
                    if (st_all_reg || pot_reg == p[0]) begin
                        saved_setting_next[p][slot_reg] = wiper_position_reg[p];
                    end
                end
                wip_next    = 1'b1;
                wr_cnt_next = CW'(WR_TIME);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int p = 0; p < POTS; p++) begin
                wiper_position_reg[p] <= WIPER_RST;
                for (int s = 0; s < SLOTS; s++) begin
                    saved_setting_slot[p][s] <= WIPER_RST;
                end
            end
            mode_reg    <= M_IDLE;
            bit_cnt_reg <= 5'h00;
            in_sh_reg   <= 8'h00;
            out_sh_reg  <= 8'h00;
            so_reg      <= 1'b0;
            so_oe_reg   <= 1'b0;
            pot_reg     <= 1'b0;
            slot_reg    <= 2'h0;
            st_pend_reg <= 1'b0;
            st_all_reg  <= 1'b0;
            wr_cnt_reg  <= '0;
            wip_reg     <= 1'b0;
        end else begin
            wiper_position_reg <= wiper_position_next;
            saved_setting_slot <= saved_setting_next;
            mode_reg    <= mode_next;
            bit_cnt_reg <= bit_cnt_next;
            in_sh_reg   <= in_sh_next;
            out_sh_reg  <= out_sh_next;
            so_reg      <= so_next;
            so_oe_reg   <= so_oe_next;
            pot_reg     <= pot_next;
            slot_reg    <= slot_next;
            st_pend_reg <= st_pend_next;
            st_all_reg  <= st_all_next;
            wr_cnt_reg  <= wr_cnt_next;
            wip_reg     <= wip_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign link.so    = so_reg;
    assign link.so_oe = so_oe_reg;
    assign wiper0_o   = wiper_position_reg[0];
    assign wiper1_o   = wiper_position_reg[1];
    assign write_in_progress_flag_o = wip_reg;
endmodule // dpsd_device

// [design/dpsd_host.sv]
// Host end: builds serial frames from user commands
`timescale 1ns/100ps
module dpsd_host
    import dpsd_pkg::*;
#(
    parameter int unsigned SCK_HALF = SCK_HALF_DEF
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // Command port
    input  wire logic        cmd_valid_i,
    output logic             cmd_ready_o,
    input  wire logic [1:0]  cmd_addr_i,
    input  wire logic [7:0]  cmd_instr_i,
    input  wire logic [7:0]  cmd_data_i,
    input  wire logic [3:0]  cmd_extra_bits_i,
    // Result
    output logic             done_o,
    output logic [7:0]       rdata_o,
    // Serial link
    dpsd_if.host             link
);
    localparam int unsigned HW = $clog2(SCK_HALF + 1);

    typedef enum logic [3:0] {
        H_IDLE  = 4'b0001,
        H_LEAD  = 4'b0010,
        H_SHIFT = 4'b0100,
        H_TAIL  = 4'b1000
    } dpsd_hstate_t;

    // Readback passes two flip-flops; sampled well before the next edge
    logic [1:0] so_sync_reg;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            so_sync_reg <= 2'h3;
        end else begin
            so_sync_reg <= {so_sync_reg[0], link.so_line};
        end
    end

    dpsd_hstate_t st_reg, st_next;
    logic [HW-1:0] div_reg, div_next;
    logic [23:0]   sh_reg, sh_next;
    logic [4:0]    nbits_reg, nbits_next;
    logic [4:0]    bits_reg, bits_next;
    logic [7:0]    rdata_reg, rdata_next;
    logic          cs_b_reg, cs_b_next;
    logic          sck_reg, sck_next;
    logic          done_reg, done_next;
    logic          tick;

    assign tick = (div_reg == HW'(SCK_HALF - 1));

    always_comb begin
        st_next    = st_reg;
        div_next   = tick ? '0 : div_reg + HW'(1);
        sh_next    = sh_reg;
        nbits_next = nbits_reg;
        bits_next  = bits_reg;
        rdata_next = rdata_reg;
        cs_b_next  = cs_b_reg;
        sck_next   = sck_reg;
        done_next  = 1'b0;
        unique case (st_reg)
            H_IDLE: begin
                div_next = '0;
                if (cmd_valid_i) begin
                    sh_next    = {DEV_ADDR_PAT, cmd_addr_i, cmd_instr_i, cmd_data_i};
                    nbits_next = 5'(HDR_BITS) + {1'b0, cmd_extra_bits_i};
                    bits_next  = 5'h00;
                    cs_b_next  = 1'b0;
                    st_next    = H_LEAD;
                end
            end
            H_LEAD: begin
                if (tick) begin
                    st_next = H_SHIFT;
                end
            end
            H_SHIFT: begin
                if (tick) begin
                    if (!sck_reg) begin
                        sck_next = 1'b1;
                    end else begin
                        sck_next   = 1'b0;
                        rdata_next = {rdata_reg[6:0], so_sync_reg[1]};
                        sh_next    = {sh_reg[22:0], 1'b0};
                        bits_next  = bits_reg + 5'h01;
                        if (bits_reg + 5'h01 == nbits_reg) begin
                            st_next = H_TAIL;
                        end
                    end
                end
            end
            H_TAIL: begin
                // Deselect ends stepping and releases any stored write
                if (tick) begin
                    cs_b_next = 1'b1;
                    done_next = 1'b1;
                    st_next   = H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg    <= H_IDLE;
            div_reg   <= '0;
            sh_reg    <= 24'h000000;
            nbits_reg <= 5'h00;
            bits_reg  <= 5'h00;
            rdata_reg <= 8'h00;
            cs_b_reg  <= 1'b1;
            sck_reg   <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            st_reg    <= st_next;
            div_reg   <= div_next;
            sh_reg    <= sh_next;
            nbits_reg <= nbits_next;
            bits_reg  <= bits_next;
            rdata_reg <= rdata_next;
            cs_b_reg  <= cs_b_next;
            sck_reg   <= sck_next;
            done_reg  <= done_next;
        end
    end

    assign link.cs_b   = cs_b_reg;
    assign link.sck    = sck_reg;
    assign link.si     = sh_reg[23];
    assign cmd_ready_o = (st_reg == H_IDLE);
    assign done_o      = done_reg;
    assign rdata_o     = rdata_reg;
endmodule // dpsd_host

// [test/dpsd_monitor.sv]
// Concurrent checks on the serial link between host and device ends
`timescale 1ns/100ps
module dpsd_monitor
    import dpsd_pkg::*;
(
    // Clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_b_i,
    // Serial link
    input  wire logic  cs_b,
    input  wire logic  sck,
    input  wire logic  si,
    input  wire logic  so,
    input  wire logic  so_oe
);
    logic        sck_reg;
    logic        sck_next;
    logic [4:0]  bit_reg;
    logic [4:0]  bit_next;

    // ---------------------------------------------------------------
    // Bit counter within a frame
    // ---------------------------------------------------------------
    // Saturates so long stepping frames never wrap into the address bits
    always_comb begin
        sck_next = sck;
        bit_next = bit_reg;
        if (cs_b) begin
            bit_next = 5'h00;
        end else if (sck && !sck_reg && bit_reg != 5'h1f) begin
            bit_next = bit_reg + 5'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sck_reg <= 1'b0;
            bit_reg <= 5'h00;
        end else begin
            sck_reg <= sck_next;
            bit_reg <= bit_next;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_high_phase;
        sck [*8] ##1 !sck;
    endsequence

    sequence s_gap;
        cs_b [*3];
    endsequence

    a_sck_high_time: assert property ($rose(sck) |-> s_high_phase)
        else $error("serial clock high phase has wrong length");
    a_sck_idle_low: assert property (cs_b |-> !sck)
        else $error("serial clock moves outside a frame");
    a_cs_gap_min: assert property ($rose(cs_b) |-> s_gap)
        else $error("chip select high gap too short");
    a_frame_len: assert property ($fell(cs_b) |-> ##[260:420] $rose(cs_b))
        else $error("frame length out of range");
    a_addr_pattern: assert property (sck && !sck_reg && bit_reg < 5'h06
        |-> si == DEV_ADDR_PAT[3'd5 - bit_reg[2:0]])
        else $error("address byte prefix wrong");
    a_si_hold_high: assert property (sck && $past(sck) |-> $stable(si))
        else $error("serial input changed while clock high");
    a_so_hold_high: assert property (so_oe && sck && $past(sck) |-> $stable(so))
        else $error("serial output changed while clock high");
    a_so_release: assert property (cs_b [*4] |-> !so_oe)
        else $error("serial output still driven after deselect");
endmodule // dpsd_monitor

// [test/tb.sv]
// Testbench joining host and device ends of the potentiometer link
`timescale 1ns/100ps
module tb;
    import dpsd_pkg::*;
    localparam int unsigned WR_T = 2000;
    localparam logic [1:0]  ADR  = 2'b10;
    logic        clk_i;
    logic        rst_b_i;
    logic        cmd_valid_i;
    logic        cmd_ready_o;
    logic [1:0]  cmd_addr_i;
    logic [7:0]  cmd_instr_i;
    logic [7:0]  cmd_data_i;
    logic [3:0]  cmd_extra_bits_i;
    logic        done_o;
    logic [7:0]  rdata_o;
    logic        strap_addr_high_i;
    logic        strap_addr_low_i;
    logic [5:0]  wiper0_o;
    logic [5:0]  wiper1_o;
    logic        write_in_progress_flag_o;
    logic [5:0]  exp0;
    logic [5:0]  exp1;
    int          err_total;
    int          checks;

    dpsd_if link ();
    dpsd_host dpsd_host_inst (.clk_i, .rst_b_i, .cmd_valid_i, .cmd_ready_o, .cmd_addr_i,
        .cmd_instr_i, .cmd_data_i, .cmd_extra_bits_i, .done_o, .rdata_o, .link(link));
    dpsd_device #(.WR_TIME(WR_T)) dpsd_device_inst (.clk_i, .rst_b_i, .link(link),
        .strap_addr_high_i, .strap_addr_low_i, .wiper0_o, .wiper1_o,
        .write_in_progress_flag_o);
    dpsd_monitor dpsd_monitor_inst (.clk_i, .rst_b_i, .cs_b(link.cs_b), .sck(link.sck),
        .si(link.si), .so(link.so), .so_oe(link.so_oe));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkw();
        chk(16'(wiper0_o), 16'(exp0));
        chk(16'(wiper1_o), 16'(exp1));
    endtask

    // Returns one step into the done pulse, before any write cycle begins
    task automatic send(input logic [1:0] a, input logic [7:0] ins, input logic [7:0] d,
                        input logic [3:0] n);
        int t;
        repeat (4) @(posedge clk_i);
        #1;
        cmd_addr_i = a;
        cmd_instr_i = ins;
        cmd_data_i = d;
        cmd_extra_bits_i = n;
        cmd_valid_i = 1'b1;
        @(posedge clk_i);
        #1;
        cmd_valid_i = 1'b0;
        chk(16'(cmd_ready_o), 16'h0000);
        t = 0;
        while (done_o !== 1'b1 && t < 1000) begin
            @(posedge clk_i);
            #1;
            t++;
        end
        chk(16'(t < 1000), 16'h0001);
        chk(16'(cmd_ready_o), 16'h0001);
    endtask

    task automatic wait_idle();
        int t;
        t = 0;
        while (write_in_progress_flag_o !== 1'b0 && t < 5000) begin
            @(posedge clk_i);
            #1;
            t++;
        end
        chk(16'(t < 5000), 16'h0001);
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_step();
        send(ADR, 8'h20, 8'hff, 4'h8);
        exp0 = 6'h08;
        send(ADR, 8'h20, 8'h00, 4'h3);
        exp0 = 6'h05;
        send(ADR, 8'h21, 8'hf0, 4'h6);
        exp1 = 6'h02;
        send(ADR, 8'h21, 8'h00, 4'h5);
        exp1 = 6'h00;
        send(ADR, 8'h21, 8'he0, 4'h3);
        exp1 = 6'h03;
        chkw();
    endtask

    // Strapped pins read 2'b10, so this frame is for another device
    task automatic t_addr_miss();
        send(2'b01, 8'h20, 8'hff, 4'h8);
        chkw();
    endtask

    task automatic t_store_busy();
        int n;
        send(ADR, 8'he4, 8'h00, 4'h0);
        chk(16'(write_in_progress_flag_o), 16'h0000);
        n = 0;
        while (write_in_progress_flag_o !== 1'b1 && n < 10) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        n = 0;
        while (write_in_progress_flag_o === 1'b1 && n < 5000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk(16'(n >= WR_T), 16'h0001);
        send(ADR, 8'h51, 8'h00, 4'h8);
        chk(16'(rdata_o), 16'h0000);
        send(ADR, 8'h88, 8'h00, 4'h0);
        send(ADR, 8'h51, 8'h00, 4'h8);
        chk(16'(rdata_o), 16'h0001);
        wait_idle();
    endtask

    task automatic t_loads();
        send(ADR, 8'h20, 8'hff, 4'h8);
        send(ADR, 8'h21, 8'hff, 4'h8);
        exp0 = 6'h0d;
        exp1 = 6'h0b;
        send(ADR, 8'hd8, 8'h00, 4'h0);
        exp0 = 6'h05;
        chkw();
        send(ADR, 8'hed, 8'h00, 4'h0);
        wait_idle();
        send(ADR, 8'h1c, 8'h00, 4'h0);
        exp0 = 6'h00;
        chkw();
        send(ADR, 8'h18, 8'h00, 4'h0);
        exp0 = 6'h05;
        exp1 = 6'h03;
        chkw();
    endtask

    // Reset in mid-run clears wipers and returns both ends to idle
    task automatic t_reset();
        repeat (4) @(posedge clk_i);
        #1;
        rst_b_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        exp0 = 6'h00;
        exp1 = 6'h00;
        chkw();
        chk(16'(rdata_o), 16'h0000);
        chk(16'(cmd_ready_o), 16'h0001);
        chk(16'(write_in_progress_flag_o), 16'h0000);
        rst_b_i = 1'b1;
        send(ADR, 8'h21, 8'hc0, 4'h2);
        exp1 = 6'h02;
        chkw();
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Roughly twenty frames and three write cycles fit well inside this
    initial begin
        #4000000;
        err_total++;
        $display("ERROR at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        err_total = 0;
        checks = 0;
        exp0 = 6'h00;
        exp1 = 6'h00;
        rst_b_i = 1'b0;
        cmd_valid_i = 1'b0;
        cmd_addr_i = 2'b00;
        cmd_instr_i = 8'h00;
        cmd_data_i = 8'h00;
        cmd_extra_bits_i = 4'h0;
        strap_addr_high_i = 1'b1;
        strap_addr_low_i = 1'b0;
        repeat (20) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        t_step();
        t_addr_miss();
        t_store_busy();
        t_loads();
        t_reset();
        end_of_test();
    end
endmodule // tb
